/* File: hdl/mfc_pkg.sv */
// Package for the MAC flow control request and indication block.
// Assumes a single 250 MHz transmit-side clock shared by all users.
package mfc_pkg;

  // Clock period and client hold guidance
  localparam int MFC_CLK_PERIOD_NS = 4;
  localparam int MFC_REQ_HOLD_NS = 205;
  localparam int MFC_REQ_HOLD_CYCLES = (MFC_REQ_HOLD_NS + MFC_CLK_PERIOD_NS - 1) / MFC_CLK_PERIOD_NS;

  // Widths and counts
  localparam int MFC_NUM_PRIO = 8;
  localparam int MFC_REFRESH_CYCLES = 8192;

  // Control frame kinds offered to the transmitter
  localparam logic MFC_KIND_PAUSE = 1'h0;
  localparam logic MFC_KIND_PFC = 1'h1;

  // Reset values
  localparam logic [MFC_NUM_PRIO-1:0] MFC_VEC_RST = 8'h00;
  localparam logic MFC_BIT_RST = 1'h0;

  typedef enum logic {MFC_IDLE, MFC_SEND} mfc_state_t;

endpackage

/* File: hdl/mfc_flow_ctrl.sv */
// Flow control request and indication logic of the MAC.
// Assumes the transmitter takes one control frame per request/ack pair
// and reports frames parsed by the receiver as one-cycle strobes.
//
// Behaviour
// [R1] While link pause request is high, a PAUSE XOFF frame is sent.
// [R2] On 10GE/25GE the client holds each request longer than 205 ns.
// [R3] Eight priority request bits; each high bit causes a PFC XOFF for its queue.
// [R4] Rising edge starts the request; client holds bit high for the pause period.
// [R5] First XOFF waits for the packet in flight, then repeats until deasserted.
// [R6] Deasserting a priority bit sends a PFC XON for that queue.
// [R7] Priority requests do nothing unless priority flow control is enabled.
// [R8] Pause-received output shows a PAUSE XOFF frame was received.
// [R9] Priority-received vector flags each queue whose PFC XOFF frame arrived.
// [R10] Signals are on the transmit clock, asynchronous on 10GE/25GE channels.
// [R11] Asynchronous requests are synchronised before their edges are detected.
`timescale 1ns/1ns

module mfc_flow_ctrl
  import mfc_pkg::*;
#(
  parameter int NUM_PRIO = MFC_NUM_PRIO,
  parameter int REFRESH_CYCLES = MFC_REFRESH_CYCLES
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  // Configuration
  input wire logic I_ASYNC_MODE,
  input wire logic I_PFC_ENABLE,
  // Client requests
  input wire logic I_TX_PAUSE,
  input wire logic [NUM_PRIO-1:0] I_TX_PFC,
  // Transmitter handshake
  input wire logic I_TX_BUSY,
  input wire logic I_FC_ACK,
  output logic O_FC_REQ,
  output logic O_FC_KIND,
  output logic [NUM_PRIO-1:0] O_FC_XOFF,
  output logic [NUM_PRIO-1:0] O_FC_XON,
  // Receiver events
  input wire logic I_RX_PAUSE_FRAME,
  input wire logic I_RX_PFC_FRAME,
  input wire logic [NUM_PRIO-1:0] I_RX_PFC_VEC,
  // Client indications
  output logic O_RX_PAUSE,
  output logic [NUM_PRIO-1:0] O_RX_PFC
);

  localparam int CW = $clog2(REFRESH_CYCLES);
  localparam logic [CW-1:0] REFRESH_LAST = CW'(REFRESH_CYCLES - 1);
  localparam logic [NUM_PRIO-1:0] ZV = '0;

  // Two-stage synchronisers; stage one feeds stage two only
  logic [NUM_PRIO:0] sync1_r;
  logic [NUM_PRIO:0] sync2_r;
  logic req_pause_w;
  logic [NUM_PRIO-1:0] req_pfc_w;
  logic [NUM_PRIO-1:0] pfc_eff_w;
  logic [NUM_PRIO-1:0] pfc_rise_w;
  logic [NUM_PRIO-1:0] pfc_fall_w;
  logic pause_rise_w;

  logic [NUM_PRIO-1:0] pfc_prev_r, pfc_prev_nxt;
  logic pause_prev_r, pause_prev_nxt;
  logic [CW-1:0] tmr_r, tmr_nxt;
  logic tick_w;

  logic pause_pend_r, pause_pend_nxt;
  logic [NUM_PRIO-1:0] xoff_pend_r, xoff_pend_nxt;
  logic [NUM_PRIO-1:0] xon_pend_r, xon_pend_nxt;

  mfc_state_t state_r, state_nxt;
  logic req_r, req_nxt;
  logic kind_r, kind_nxt;
  logic [NUM_PRIO-1:0] xoff_r, xoff_nxt;
  logic [NUM_PRIO-1:0] xon_r, xon_nxt;
  logic sent_w;

  logic rx_pause_r, rx_pause_nxt;
  logic [NUM_PRIO-1:0] rx_pfc_r, rx_pfc_nxt;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {I_TX_PAUSE, I_TX_PFC}; // R11
      sync2_r <= sync1_r; // R11
    end
  end

  // Synchronous channels skip the two-cycle delay
  always_comb begin
    req_pause_w = I_ASYNC_MODE ? sync2_r[NUM_PRIO] : I_TX_PAUSE; // R10
    req_pfc_w = I_ASYNC_MODE ? sync2_r[NUM_PRIO-1:0] : I_TX_PFC; // R10
    pfc_eff_w = I_PFC_ENABLE ? req_pfc_w : ZV; // R7
    pfc_rise_w = pfc_eff_w & ~pfc_prev_r; // R4
    pfc_fall_w = I_PFC_ENABLE ? (~pfc_eff_w & pfc_prev_r) : ZV; // R6
    pause_rise_w = req_pause_w & ~pause_prev_r; // R1
    tick_w = (tmr_r == REFRESH_LAST);
    sent_w = (state_r == MFC_SEND) && I_FC_ACK;
  end

  // Edge history and refresh timer
  always_comb begin
    pfc_prev_nxt = pfc_eff_w;
    pause_prev_nxt = req_pause_w;
    tmr_nxt = tick_w ? '0 : tmr_r + 1'b1;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      pfc_prev_r <= MFC_VEC_RST;
      pause_prev_r <= MFC_BIT_RST;
      tmr_r <= '0;
    end else begin
      pfc_prev_r <= pfc_prev_nxt;
      pause_prev_r <= pause_prev_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // Pending frames; a new set beats the clear from a sent frame
  always_comb begin
    pause_pend_nxt = pause_pend_r & ~(sent_w && kind_r == MFC_KIND_PAUSE);
    if (pause_rise_w || (tick_w && req_pause_w)) begin
      pause_pend_nxt = 1'b1; // R1
    end
    if (!req_pause_w) begin
      pause_pend_nxt = 1'b0;
    end
    xoff_pend_nxt = xoff_pend_r & ~((sent_w && kind_r == MFC_KIND_PFC) ? xoff_r : ZV);
    xon_pend_nxt = xon_pend_r & ~((sent_w && kind_r == MFC_KIND_PFC) ? xon_r : ZV);
    xoff_pend_nxt = (xoff_pend_nxt & ~pfc_fall_w) | pfc_rise_w | (tick_w ? pfc_eff_w : ZV); // R3 R5
    xon_pend_nxt = (xon_pend_nxt & ~pfc_rise_w) | pfc_fall_w; // R6
    if (!I_PFC_ENABLE) begin
      xoff_pend_nxt = ZV; // R7
      xon_pend_nxt = ZV; // R7
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      pause_pend_r <= MFC_BIT_RST;
      xoff_pend_r <= MFC_VEC_RST;
      xon_pend_r <= MFC_VEC_RST;
    end else begin
      pause_pend_r <= pause_pend_nxt;
      xoff_pend_r <= xoff_pend_nxt;
      xon_pend_r <= xon_pend_nxt;
    end
  end

  // Frame launcher: one frame at a time, link pause ahead of priority frames
  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    kind_nxt = kind_r;
    xoff_nxt = xoff_r;
    xon_nxt = xon_r;
    case (state_r)
      MFC_IDLE: begin
        if (!I_TX_BUSY && (pause_pend_r || |xoff_pend_r || |xon_pend_r)) begin // R5
          state_nxt = MFC_SEND;
          req_nxt = 1'b1;
          kind_nxt = pause_pend_r ? MFC_KIND_PAUSE : MFC_KIND_PFC; // R1
          xoff_nxt = pause_pend_r ? ZV : xoff_pend_r; // R3
          xon_nxt = pause_pend_r ? ZV : xon_pend_r; // R6
        end
      end
      MFC_SEND: begin
        if (I_FC_ACK) begin
          state_nxt = MFC_IDLE;
          req_nxt = 1'b0;
          xoff_nxt = ZV;
          xon_nxt = ZV;
        end
      end
      default: begin
        state_nxt = MFC_IDLE;
        req_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      state_r <= MFC_IDLE;
      req_r <= MFC_BIT_RST;
      kind_r <= MFC_KIND_PAUSE;
      xoff_r <= MFC_VEC_RST;
      xon_r <= MFC_VEC_RST;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      kind_r <= kind_nxt;
      xoff_r <= xoff_nxt;
      xon_r <= xon_nxt;
    end
  end

  // Receive indications, one cycle per parsed frame
  always_comb begin
    rx_pause_nxt = I_RX_PAUSE_FRAME; // R8
    rx_pfc_nxt = I_RX_PFC_FRAME ? I_RX_PFC_VEC : ZV; // R9
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RESET_N) begin
      rx_pause_r <= MFC_BIT_RST;
      rx_pfc_r <= MFC_VEC_RST;
    end else begin
      rx_pause_r <= rx_pause_nxt;
      rx_pfc_r <= rx_pfc_nxt;
    end
  end

  assign O_FC_REQ = req_r;
  assign O_FC_KIND = kind_r;
  assign O_FC_XOFF = xoff_r;
  assign O_FC_XON = xon_r;
  assign O_RX_PAUSE = rx_pause_r;
  assign O_RX_PFC = rx_pfc_r;

  property p_pause_arm;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    pause_rise_w |=> pause_pend_r || !req_pause_w;
  endproperty
  a_pause_arm: assert property (p_pause_arm) else $error("pause request not armed"); // R1

  property p_xoff_arm;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (|pfc_rise_w) && I_PFC_ENABLE ##1 I_PFC_ENABLE |-> ((xoff_pend_r & $past(pfc_rise_w)) == $past(pfc_rise_w));
  endproperty
  a_xoff_arm: assert property (p_xoff_arm) else $error("priority xoff not armed"); // R3

  property p_xon_arm;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (|pfc_fall_w) ##1 I_PFC_ENABLE |-> ((xon_pend_r & $past(pfc_fall_w)) == $past(pfc_fall_w));
  endproperty
  a_xon_arm: assert property (p_xon_arm) else $error("priority xon not armed"); // R6

  property p_wait_idle_tx;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    $rose(O_FC_REQ) |-> !$past(I_TX_BUSY);
  endproperty
  a_wait_idle_tx: assert property (p_wait_idle_tx) else $error("frame launched during packet"); // R5

  property p_req_hold;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    O_FC_REQ && !I_FC_ACK |=> O_FC_REQ && $stable(O_FC_XOFF) && $stable(O_FC_KIND);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before ack"); // R5

  property p_pfc_gate;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    !I_PFC_ENABLE |=> xoff_pend_r == ZV && xon_pend_r == ZV;
  endproperty
  a_pfc_gate: assert property (p_pfc_gate) else $error("priority pending while disabled"); // R7

  property p_rx_pause;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    I_RX_PAUSE_FRAME |=> O_RX_PAUSE ##1 (O_RX_PAUSE == $past(I_RX_PAUSE_FRAME));
  endproperty
  a_rx_pause: assert property (p_rx_pause) else $error("pause receipt not shown"); // R8

  property p_rx_pfc;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    I_RX_PFC_FRAME |=> O_RX_PFC == $past(I_RX_PFC_VEC);
  endproperty
  a_rx_pfc: assert property (p_rx_pfc) else $error("priority receipt vector wrong"); // R9

  property p_async_delay;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    I_ASYNC_MODE && $past(I_ASYNC_MODE) && $rose(req_pause_w) |-> $past(I_TX_PAUSE, 2) && !$past(I_TX_PAUSE, 3);
  endproperty
  a_async_delay: assert property (p_async_delay) else $error("async request not synchronised"); // R11

endmodule

/* File: bench/mfc_tx_model.sv */
// Transmitter-side partner: takes each offered control frame with an ack pulse.
// Assumes the request stays up until the ack is seen.
`timescale 1ns/1ns

module mfc_tx_model (
  // Clock and pacing
  input wire logic i_clk,
  input wire logic i_slow,
  // Handshake
  input wire logic i_req,
  output logic o_ack
);
  int wait_cnt = 0;

  // Slow mode stalls the launcher so the held frame can be observed
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    if (i_req && !o_ack) begin
      if (wait_cnt >= (i_slow ? 6 : 1)) begin
        o_ack <= 1'b1;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the flow control block.
// Assumes mfc_tx_model acks frames; refresh shortened to 16 cycles.
`timescale 1ns/1ns

module testbench;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic async_mode = 1'b0;
  logic pfc_en = 1'b1;
  logic tx_pause = 1'b0;
  logic [7:0] tx_pfc = 8'h00;
  logic tx_busy = 1'b0;
  logic slow = 1'b0;
  logic rx_pause = 1'b0;
  logic rx_pfc = 1'b0;
  logic [7:0] rx_vec = 8'h00;
  logic fc_ack, fc_req, fc_kind, rx_pause_out, f_kind;
  logic [7:0] fc_xoff, fc_xon, rx_pfc_out, f_xoff, f_xon, m;
  int bad_count = 0;
  int tests_run = 0;

  mfc_flow_ctrl #(.REFRESH_CYCLES(16)) u_dut (.I_REF_CLK(ref_clk), .I_RESET_N(reset_n),
    .I_ASYNC_MODE(async_mode), .I_PFC_ENABLE(pfc_en), .I_TX_PAUSE(tx_pause), .I_TX_PFC(tx_pfc),
    .I_TX_BUSY(tx_busy), .I_FC_ACK(fc_ack), .O_FC_REQ(fc_req), .O_FC_KIND(fc_kind),
    .O_FC_XOFF(fc_xoff), .O_FC_XON(fc_xon), .I_RX_PAUSE_FRAME(rx_pause), .I_RX_PFC_FRAME(rx_pfc),
    .I_RX_PFC_VEC(rx_vec), .O_RX_PAUSE(rx_pause_out), .O_RX_PFC(rx_pfc_out));
  mfc_tx_model u_tx (.i_clk(ref_clk), .i_slow(slow), .i_req(fc_req), .o_ack(fc_ack));

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Receive indication expected one cycle after the strobe
  function automatic logic [7:0] exp_rx_pfc(input logic frame, input logic [7:0] vec);
    return frame ? vec : 8'h00;
  endfunction

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  // Captures one offered frame, then waits for the launcher to go idle
  task automatic get_frame();
    int n;
    n = 0;
    while (fc_req !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    check("fc_req", {7'h00, fc_req}, 8'h01);
    f_kind = fc_kind;
    f_xoff = fc_xoff;
    f_xon = fc_xon;
    while (fc_req === 1'b1 && n < 600) begin
      tick(1);
      n++;
    end
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      tick(1);
      check("no_frame", {7'h00, fc_req}, 8'h00);
    end
  endtask

  // Stale refresh frames may precede the release frame
  task automatic fall(input logic [7:0] exp);
    tx_pfc = 8'h00;
    for (int i = 0; i < 4; i++) begin
      get_frame();
      if (f_xon !== 8'h00) break;
    end
    check("xon", f_xon, exp);
    check("xoff_on_release", f_xoff, 8'h00);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #80000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h903C));
    tick(2);
    reset_n = 1'b1;
    m = 8'h01 << $urandom_range(7, 0);
    tx_pfc = m;
    get_frame();
    check("kind", {7'h00, f_kind}, 8'h01);
    check("xoff", f_xoff, m);
    check("xon", f_xon, 8'h00);
    get_frame();
    check("xoff_refresh", f_xoff, m);
    tx_busy = 1'b1;
    quiet(30);
    tx_busy = 1'b0;
    get_frame();
    check("xoff_after_busy", f_xoff, m);
    fall(m);
    slow = 1'b1;
    tx_pfc = 8'hFF;
    get_frame();
    check("xoff_all", f_xoff, 8'hFF);
    fall(8'hFF);
    slow = 1'b0;
    pfc_en = 1'b0;
    tx_pfc = 8'(($urandom_range(254, 0)) + 1);
    quiet(40);
    tx_pfc = 8'h00;
    quiet(40);
    pfc_en = 1'b1;
    tx_pause = 1'b1;
    get_frame();
    check("pause_kind", {7'h00, f_kind}, 8'h00);
    check("pause_xoff", f_xoff | f_xon, 8'h00);
    tx_pause = 1'b0;
    tick(20);
    async_mode = 1'b1;
    tick(4);
    m = 8'h01 << $urandom_range(7, 0);
    tx_pfc = m;
    get_frame();
    check("async_xoff", f_xoff, m);
    tick(60);
    fall(m);
    tx_pause = 1'b1;
    get_frame();
    check("async_pause_kind", {7'h00, f_kind}, 8'h00);
    tick(60);
    tx_pause = 1'b0;
    tick(20);
    repeat (40) begin
      rx_pause = 1'($urandom);
      rx_pfc = 1'($urandom);
      rx_vec = 8'($urandom);
      tick(1);
      check("rx_pause", {7'h00, rx_pause_out}, {7'h00, rx_pause});
      check("rx_pfc", rx_pfc_out, exp_rx_pfc(rx_pfc, rx_vec));
    end
    report_and_stop();
  end
endmodule
